// ### hw/pcc_pkg.sv
// constants for the configuration header front: ids, offsets, command fields
package pcc_pkg;
  // register byte offsets in configuration space
  localparam logic [7:0]  PCC_MAKER_CODE_OFS    = 8'h00;
  localparam logic [7:0]  PCC_FUNCTION_CODE_OFS = 8'h02;
  localparam logic [7:0]  PCC_FUNCTION_CMD_OFS  = 8'h04;
  // identity values: arbitrary neutral codes, not those of any real part
  localparam logic [15:0] PCC_MAKER_CODE_VAL    = 16'h1AB5;
  localparam logic [15:0] PCC_FUNCTION_CODE_VAL = 16'h0C3E;
  // command register reset value and field positions
  localparam logic [15:0] PCC_CMD_RESET         = 16'h0000;
  localparam int          PCC_IO_SPACE_EN_BIT   = 0;
  localparam int          PCC_MEM_SPACE_EN_BIT  = 1;
  localparam int          PCC_MASTER_EN_BIT     = 2;
  localparam int          PCC_INT_INHIBIT_BIT   = 10;
  // only bits 10, 2, 1 and 0 hold state; all else reads zero
  localparam logic [15:0] PCC_CMD_WR_MASK       = 16'h0407;
endpackage

// ### hw/pcc_config_front.sv
// configuration header front: identity words and the command register
`timescale 1ns/1ps

// Overview of operation
// - read-only 16-bit maker code, writes ignored
// - read-only 16-bit function code identifies function
// - command register at 04h, resets to zero
// - inhibit bit 10 clear allows interrupt pin
// - inhibit set: no pin, no assert messages
// - bit 2 gates all bus mastering
// - bit 1 gates memory-space claims
// - bit 0 gates I/O-space claims
// - bits 9, 8, 7 read zero, unwritable
// - bit 6 zero; parity errors ignored
// - bit 5 zero; palette snooping disabled
// - bit 4 zero; no write-invalidate commands
// - bit 3 zero; special cycles ignored
// - pin asserts only when status set, uninhibited
module pcc_config_front
  import pcc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // configuration access from the host bridge
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [5:0]  cfg_dword,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack_q,
  output logic      [31:0] cfg_rdata_q,
  // function-side requests
  input  wire logic        irq_status,
  input  wire logic        master_req,
  input  wire logic        mem_hit,
  input  wire logic        io_hit,
  // gated responses
  output logic             master_ok_q,
  output logic             mem_claim_q,
  output logic             io_claim_q,
  // legacy interrupt pin, open drain, and upstream messages
  output logic             intx_o_q,
  output logic             intx_oe_n_q,
  output logic             int_msg_assert_q,
  output logic             int_msg_deassert_q
);

  // dword index of a byte offset; used by every decode
  function automatic logic [5:0] dword_of(input logic [7:0] ofs);
    dword_of = ofs[7:2];
  endfunction

  logic [15:0] cmd_q;
  logic        int_eff_d;
  logic        wr_cmd;

  // only the command dword accepts writes; identity dword drops them
  assign wr_cmd = cfg_req
                  & cfg_we
                  & (cfg_dword == dword_of(PCC_FUNCTION_CMD_OFS));

  // command register: masked so hardwired bits can never become set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_q <= PCC_CMD_RESET;
    else if (ce && wr_cmd)
    begin
      if (cfg_be[0])
        cmd_q[7:0] <= cfg_wdata[7:0]
                      & PCC_CMD_WR_MASK[7:0];
      if (cfg_be[1])
        cmd_q[15:8] <= cfg_wdata[15:8] & PCC_CMD_WR_MASK[15:8];
    end
  end

  // read answer one edge after the request; unmapped dwords read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      cfg_ack_q <= cfg_req;
      if (cfg_req && !cfg_we)
      begin
        if (cfg_dword == dword_of(PCC_MAKER_CODE_OFS))
          cfg_rdata_q <= {PCC_FUNCTION_CODE_VAL,
                          PCC_MAKER_CODE_VAL};
        else if (cfg_dword == dword_of(PCC_FUNCTION_CMD_OFS))
          cfg_rdata_q <= {16'h0000, cmd_q}; // status half left at zero
        else
          cfg_rdata_q <= 32'h0000_0000;
      end
      else
        cfg_rdata_q <= 32'h0000_0000;
    end
  end

  // space and master gating; parity and special cycles have no input at all
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_ok_q <= 1'b0;
      mem_claim_q <= 1'b0;
      io_claim_q  <= 1'b0;
    end
    else if (ce)
    begin
      master_ok_q <= master_req & cmd_q[PCC_MASTER_EN_BIT];
      mem_claim_q <= mem_hit & cmd_q[PCC_MEM_SPACE_EN_BIT];
      io_claim_q  <= io_hit & cmd_q[PCC_IO_SPACE_EN_BIT];
    end
  end

  // inhibit masks the pin and the assert message; irq_status itself is never touched
  assign int_eff_d = irq_status & ~cmd_q[PCC_INT_INHIBIT_BIT];

  // pin and message edges share one state so they cannot disagree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intx_o_q           <= 1'b0;
      intx_oe_n_q        <= 1'b1;
      int_msg_assert_q   <= 1'b0;
      int_msg_deassert_q <= 1'b0;
    end
    else if (ce)
    begin
      intx_o_q           <= 1'b0;        // open drain only ever pulls low
      intx_oe_n_q        <= ~int_eff_d;
      int_msg_assert_q   <= int_eff_d & intx_oe_n_q;
      int_msg_deassert_q <= ~int_eff_d & ~intx_oe_n_q; // inhibit also releases
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  inhibit_blocks_pin_a: assert property (
    ce && cmd_q[PCC_INT_INHIBIT_BIT] |=> intx_oe_n_q)
    else $error("interrupt pin driven while inhibited");
  pin_follows_status_a: assert property (
    ce && irq_status && !cmd_q[PCC_INT_INHIBIT_BIT] |=> !intx_oe_n_q)
    else $error("interrupt pin not driven for pending status");
  no_msg_inhibited_a: assert property (
    ce && cmd_q[PCC_INT_INHIBIT_BIT] |=> !int_msg_assert_q)
    else $error("assert message sent while inhibited");
  pin_needs_status_a: assert property (
    ce && !irq_status |=> intx_oe_n_q)
    else $error("interrupt pin driven without status");
  master_gate_a: assert property (
    ce && !cmd_q[PCC_MASTER_EN_BIT] |=> !master_ok_q)
    else $error("mastering allowed while disabled");
  mem_claim_gate_a: assert property (
    ce && mem_hit |=> mem_claim_q == $past(cmd_q[PCC_MEM_SPACE_EN_BIT]))
    else $error("memory claim does not follow enable");
  io_claim_gate_a: assert property (
    ce && io_hit |=> io_claim_q == $past(cmd_q[PCC_IO_SPACE_EN_BIT]))
    else $error("io claim does not follow enable");
  hardwired_zero_a: assert property (
    (cmd_q & ~PCC_CMD_WR_MASK) == 16'h0000)
    else $error("hardwired command bit set");
  id_read_value_a: assert property (
    ce && cfg_req && !cfg_we && cfg_dword == 6'h00 |=> cfg_ack_q
      && cfg_rdata_q == {PCC_FUNCTION_CODE_VAL, PCC_MAKER_CODE_VAL})
    else $error("identity read wrong");
  id_write_ignored_a: assert property (
    ce && cfg_req && cfg_we && cfg_dword == 6'h00 |=> $stable(cmd_q))
    else $error("identity write changed state");

  // bus answer: every taken access is acknowledged on the next edge
  ack_follows_req_a: assert property (
    ce && cfg_req |=> cfg_ack_q)
    else $error("access not acknowledged");
  cmd_read_value_a: assert property (
    ce && cfg_req && !cfg_we
      && cfg_dword == dword_of(PCC_FUNCTION_CMD_OFS)
      |=> cfg_rdata_q == {16'h0000, $past(cmd_q)})
    else $error("command read wrong");
  unmapped_read_zero_a: assert property (
    ce && cfg_req && !cfg_we
      && cfg_dword > dword_of(PCC_FUNCTION_CMD_OFS)
      |=> cfg_rdata_q == 32'h0000_0000)
    else $error("unmapped read not zero");

  // a low enable must freeze the command word, the answer and the pin
  ce_freezes_state_a: assert property (
    !ce |=> $stable(cmd_q) && $stable(cfg_ack_q) && $stable(intx_oe_n_q))
    else $error("state moved while enable low");

  // writes land in live bits; inhibit and master bits follow the data
  inhibit_write_a: assert property (
    ce && wr_cmd && cfg_be[1] && cfg_wdata[PCC_INT_INHIBIT_BIT]
      |=> cmd_q[PCC_INT_INHIBIT_BIT])
    else $error("inhibit bit did not take a written one");
  master_clear_a: assert property (
    ce && wr_cmd && cfg_be[0] && !cfg_wdata[PCC_MASTER_EN_BIT]
      |=> !cmd_q[PCC_MASTER_EN_BIT])
    else $error("master enable did not clear");

  // claims never appear without a decoded hit
  mem_needs_hit_a: assert property (
    ce && !mem_hit |=> !mem_claim_q)
    else $error("memory claim without hit");
  io_needs_hit_a: assert property (
    ce && !io_hit |=> !io_claim_q)
    else $error("io claim without hit");

  // message pulses mark each edge of the effective interrupt
  msg_on_rise_a: assert property (
    ce && irq_status && !cmd_q[PCC_INT_INHIBIT_BIT] && intx_oe_n_q
      |=> int_msg_assert_q)
    else $error("no assert message on interrupt rise");
  msg_on_fall_a: assert property (
    ce && !intx_oe_n_q && (!irq_status || cmd_q[PCC_INT_INHIBIT_BIT])
      |=> int_msg_deassert_q)
    else $error("no deassert message on interrupt fall");
  pin_never_high_a: assert property (
    !intx_o_q)
    else $error("open-drain data driven high");

  cmd_written_c:  cover property (ce && wr_cmd && cfg_be[0]);
  int_asserted_c: cover property (
    int_msg_assert_q ##[1:20] int_msg_deassert_q);
  mem_claimed_c:  cover property (mem_claim_q);
  master_ok_c:    cover property (master_ok_q);
  inhibited_c:    cover property (irq_status && cmd_q[PCC_INT_INHIBIT_BIT]);

endmodule

// ### test/pcc_host_model.sv
// host bridge model: issues configuration reads and writes
`timescale 1ns/1ps
module pcc_host_model
(
  // bus to the device
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  output logic             req,
  output logic             we,
  output logic [5:0]       dw,
  output logic [3:0]       be,
  output logic [31:0]      wd
);
  initial {req, we, dw, be, wd} = '0;
  // one access, held through the edge that takes it; the answer stands
  // for one cycle after that edge, so it is read at the next falling edge
  task automatic acc(input logic w, input logic [5:0] d, input logic [3:0] b,
                     input logic [31:0] v, output logic [31:0] r,
                     output logic a);
    @(negedge clk);
    {req, we, dw, be, wd} = {1'b1, w, d, b, v};
    @(negedge clk);
    r = rdata;
    a = ack;
    req = 1'b0;
    wd = ~v;  // stale data must not look valid
  endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the configuration header front
`timescale 1ns/1ps
module tb_top;
  import pcc_pkg::*;
  logic        clk = 0, rst_n = 0, irq = 0, mrq = 0, mh = 0, ih = 0;
  logic        ce = 1'b1;
  logic        req, we, ack, mok, mcl, icl, io, oen, ma, md, a, e, pe;
  logic [5:0]  dw;
  logic [3:0]  be, b;
  logic [31:0] wd, rd, r, v;
  logic [15:0] cmd;
  int          n_fail = 0, tests_run = 0, cyc = 0;
  always #20 clk = ~clk;
  pcc_host_model host (.clk(clk), .ack(ack), .rdata(rd), .req(req), .we(we),
                       .dw(dw), .be(be), .wd(wd));
  pcc_config_front DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .cfg_req(req),
    .cfg_we(we), .cfg_dword(dw), .cfg_be(be), .cfg_wdata(wd),
    .cfg_ack_q(ack), .cfg_rdata_q(rd), .irq_status(irq), .master_req(mrq),
    .mem_hit(mh), .io_hit(ih), .master_ok_q(mok), .mem_claim_q(mcl),
    .io_claim_q(icl), .intx_o_q(io), .intx_oe_n_q(oen),
    .int_msg_assert_q(ma), .int_msg_deassert_q(md));
  // command after a write: only live bits in enabled lanes change
  function automatic logic [15:0] nx(logic [15:0] c, logic [31:0] w,
                                     logic [3:0] l);
    logic [15:0] m;
    m = PCC_CMD_WR_MASK & {{8{l[1]}}, {8{l[0]}}};
    return (c & ~m) | (w[15:0] & m);
  endfunction
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic end_of_test();
    $display("n_fail %0d tests_run %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, generous against about 1000 cycles of traffic
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // main sequence: reset, identity, then random command and traffic
  initial
  begin
    void'($urandom(32'hEAED9353));
    cmd = 16'h0000;
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    host.acc(1'b0, 6'h01, 4'hF, '0, r, a);
    chk("cmd reset", 32'h0000_0000, r);
    chk("ack", 32'h1, {31'h0, a});
    host.acc(1'b1, 6'h00, 4'hF, $urandom, r, a);
    host.acc(1'b0, 6'h00, 4'h0, '0, r, a);
    chk("ids", {PCC_FUNCTION_CODE_VAL, PCC_MAKER_CODE_VAL}, r);
    host.acc(1'b0, 6'h05, 4'h0, '0, r, a);
    chk("unmapped", 32'h0000_0000, r);
    for (int i = 0; i < 200; i++)
    begin
      v = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      b = (i == 0) ? 4'hF : 4'($urandom);
      host.acc(1'b1, 6'h01, b, v, r, a);
      cmd = nx(cmd, v, b);
      host.acc(1'b0, 6'h01, 4'h0, '0, r, a);
      chk("cmd", {16'h0000, cmd}, r);
      pe = irq & ~cmd[10];
      {irq, mrq, mh, ih} = 4'($urandom);
      e = irq & ~cmd[10];
      @(negedge clk);
      chk("master", {31'h0, mrq & cmd[2]}, {31'h0, mok});
      chk("mem claim", {31'h0, mh & cmd[1]}, {31'h0, mcl});
      chk("io claim", {31'h0, ih & cmd[0]}, {31'h0, icl});
      chk("pin", {30'h0, ~e, 1'b0}, {30'h0, oen, io});
      chk("messages", {30'h0, e & ~pe, pe & ~e}, {30'h0, ma, md});
    end
    // enable low: a write must not land and the answer stays frozen
    @(negedge clk) ce = 1'b0;
    host.acc(1'b1, 6'h01, 4'hF, {16'h0000, ~cmd}, r, a);
    chk("frozen ack", 32'h0000_0000, {31'h0, a});
    @(negedge clk) ce = 1'b1;
    host.acc(1'b0, 6'h01, 4'h0, '0, r, a);
    chk("cmd frozen", {16'h0000, cmd}, r);
    // reset in mid-run must clear a live command word
    host.acc(1'b1, 6'h01, 4'h3, {16'h0000, PCC_CMD_WR_MASK}, r, a);
    {irq, mrq, mh, ih} = 4'h0;
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("pin in reset", 32'h1, {31'h0, oen});
    rst_n = 1'b1;
    cmd = PCC_CMD_RESET;
    host.acc(1'b0, 6'h01, 4'h0, '0, r, a);
    chk("cmd after reset", {16'h0000, cmd}, r);
    end_of_test();
  end
endmodule
